// ===== hdl/ocs_top.sv
// Overview of operation
// - PLL output divider: 1..64 powers, 111=256
// - FAST_RC_OSC divider same encoding, reset divide-by-two
// - secondary ready bit follows stable oscillator while enable bit 1 is set
// - periph divider writable only when ready
// - periph bus divide 1,2,4,8; default 8
// - multiplier codes give 15..21, 111=24
// - current source reported in bits 14-12
// - new source loaded from configuration on reset
// - lock bit freezes selections when monitor 1x
// - monitor 0x: selections never locked
// - USB PLL lock bit from lock/timer, gated by USB PLL enabled
// - system PLL lock bit from lock/timer
// - wait enters Sleep or Idle by bit
// - clock-fail flag set on monitor failure
// - USB clock from FAST_RC_OSC when bit set
// - secondary oscillator enable follows bit 1
// - switch request bit self-clears on completion
// - control and tuning writes need the unlock sequence first
// - clear, set, invert aliases at 4, 8, C
// - six-bit signed FAST_RC_OSC trim field
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module ocs_top
    import ocs_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // configuration word
    input  wire logic [2:0]            config_initial_source,
    input  wire logic [1:0]            switch_monitor_config,
    input  wire logic [2:0]            config_pll_out_div,
    input  wire logic [2:0]            config_pll_mult,
    input  wire logic [1:0]            config_pbus_div,
    input  wire logic                  config_pbus_div_valid,
    // oscillator status and core events
    input  wire ocs_pkg::ocs_status_type osc_status,
    input  wire logic                  wait_instr,
    input  wire logic                  wake_event,
    // clock tree controls
    output ocs_pkg::ocs_ctrl_type      clk_ctrl
);
    import ocs_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0]       odiv_reg;
    logic [2:0]       fast_rc_divider_reg;
    logic [1:0]       periph_bus_divider_reg;
    logic [2:0]       mult_reg;
    logic [2:0]       cur_reg;
    logic [2:0]       new_reg;
    logic             lock_reg;
    logic             sleep_reg;
    logic             fail_reg;
    logic             ufrc_reg;
    logic             secondary_osc_enable_reg;
    logic             swreq_reg;
    logic [31:0]      tun_reg;
    logic [31:0]      refctl_reg;
    logic [31:0]      reftrim_reg;
    logic [1:0]       unlock_reg;
    logic             unlocked;
    logic             cfg_loaded_reg;
    logic [7:0]       sw_cnt_reg;
    ocs_sw_state_type sw_state_reg;
    logic             pd_busy_reg;
    logic             low_power_reg;

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic             dp_wr_reg;
    logic             dp_rd_reg;
    logic [15:0]      dp_addr_reg;
    logic             ap_valid;

    assign ap_valid  = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dp_wr_reg   <= 1'b0;
            dp_rd_reg   <= 1'b0;
            dp_addr_reg <= 16'h0000;
        end
        else if (hready)
        begin
            dp_wr_reg   <= ap_valid && hwrite;
            dp_rd_reg   <= ap_valid && !hwrite;
            dp_addr_reg <= haddr[15:0];
        end
    end

    // ------------------------------------------------------------
    // write decode with alias operations
    // ------------------------------------------------------------
    logic [15:0] base_addr;
    logic [1:0]  alias_op;
    logic        hit_ctl;
    logic        hit_tun;
    logic        hit_rctl;
    logic        hit_rtrim;
    logic        hit_key;
    logic [31:0] ctl_word;
    logic        sel_locked;

    assign base_addr = {dp_addr_reg[15:4], 4'h0};
    assign alias_op  = dp_addr_reg[3:2];
    assign hit_ctl   = dp_wr_reg && (base_addr == OCS_OFF_CONTROL) && unlocked;
    assign hit_tun   = dp_wr_reg && (base_addr == OCS_OFF_TUNING) && unlocked;
    assign hit_rctl  = dp_wr_reg && (base_addr == OCS_OFF_REFCTRL);
    assign hit_rtrim = dp_wr_reg && (base_addr == OCS_OFF_REFTRIM);
    assign hit_key   = dp_wr_reg && (dp_addr_reg == OCS_OFF_UNLOCK);
    assign unlocked  = (unlock_reg == 2'h2);

    // lock only matters when switching and monitoring is disabled
    assign sel_locked = switch_monitor_config[1] && lock_reg;

    function automatic logic [31:0] apply_alias(input logic [31:0] old_val,
                                               input logic [31:0] wdata,
                                               input logic [1:0]  op);
        logic [31:0] res;
        res = old_val;
        case (op)
            OCS_ALIAS_BASE: res = wdata;
            OCS_ALIAS_CLR:  res = old_val & ~wdata;
            OCS_ALIAS_SET:  res = old_val | wdata;
            OCS_ALIAS_INV:  res = old_val ^ wdata;
            default:        res = old_val;
        endcase
        return res;
    endfunction

    logic [31:0] ctl_new;
    assign ctl_new = apply_alias(ctl_word, hwdata, alias_op);

    // ------------------------------------------------------------
    // unlock sequence: two keys in order, consumed by the next write
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            unlock_reg <= 2'h0;
        else if (hit_key && hwdata == OCS_KEY_1)
            unlock_reg <= 2'h1;
        else if (hit_key && hwdata == OCS_KEY_2 && unlock_reg == 2'h1)
            unlock_reg <= 2'h2;
        else if (dp_wr_reg)
            unlock_reg <= 2'h0;
    end

    // ------------------------------------------------------------
    // configuration load after reset release
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            cfg_loaded_reg <= 1'b0;
        else
            cfg_loaded_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // clock selection and PLL settings
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            odiv_reg <= OCS_RST_ODIV;
            mult_reg <= OCS_RST_MULT;
            new_reg  <= OCS_RST_SRC;
            cur_reg  <= OCS_RST_SRC;
        end
        else if (!cfg_loaded_reg)
        begin
            odiv_reg <= config_pll_out_div;
            mult_reg <= config_pll_mult;
            new_reg  <= config_initial_source;
            cur_reg  <= config_initial_source;
        end
        else
        begin
            if (hit_ctl && !sel_locked)
            begin
                odiv_reg <= ctl_new[OCS_POS_ODIV +: 3];
                mult_reg <= ctl_new[OCS_POS_MULT +: 3];
                new_reg  <= ctl_new[OCS_POS_NEW +: 3];
            end
            if (sw_state_reg == OCS_SW_DONE)
                cur_reg <= new_reg;
        end
    end

    // ------------------------------------------------------------
    // plain control bits
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fast_rc_divider_reg <= OCS_RST_FAST_RC_DIVIDER;
            lock_reg   <= 1'b0;
            sleep_reg  <= 1'b0;
            ufrc_reg   <= 1'b0;
            secondary_osc_enable_reg <= 1'b0;
            tun_reg    <= 32'h00000000;
        end
        else
        begin
            if (hit_ctl)
            begin
                fast_rc_divider_reg <= ctl_new[OCS_POS_FAST_RC_DIVIDER +: 3];
                // once set the lock stays until reset
                lock_reg   <= lock_reg | ctl_new[OCS_POS_LOCK];
                sleep_reg  <= ctl_new[OCS_POS_SLEEP];
                ufrc_reg   <= ctl_new[OCS_POS_UFRC];
                secondary_osc_enable_reg <= ctl_new[OCS_POS_SECONDARY_OSC_ENABLE];
            end
            if (hit_tun)
                tun_reg <= apply_alias(tun_reg, hwdata, alias_op) & OCS_WMASK_TUNING;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            refctl_reg  <= 32'h00000000;
            reftrim_reg <= 32'h00000000;
        end
        else
        begin
            if (hit_rctl)
                refctl_reg <= apply_alias(refctl_reg, hwdata, alias_op) & OCS_WMASK_REFCTRL;
            if (hit_rtrim)
                reftrim_reg <= apply_alias(reftrim_reg, hwdata, alias_op) & OCS_WMASK_REFTRIM;
        end
    end

    // ------------------------------------------------------------
    // peripheral bus divider with its ready handshake
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            periph_bus_divider_reg   <= OCS_RST_PERIPH_BUS_DIVIDER;
            pd_busy_reg <= 1'b0;
        end
        else if (!cfg_loaded_reg)
        begin
            if (config_pbus_div_valid)
                periph_bus_divider_reg <= config_pbus_div;
            pd_busy_reg <= 1'b0;
        end
        else if (hit_ctl && !pd_busy_reg &&
                 ctl_new[OCS_POS_PERIPH_BUS_DIVIDER +: 2] != periph_bus_divider_reg)
        begin
            periph_bus_divider_reg   <= ctl_new[OCS_POS_PERIPH_BUS_DIVIDER +: 2];
            pd_busy_reg <= 1'b1;
        end
        else
            pd_busy_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // oscillator switch sequencer
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sw_state_reg <= OCS_SW_IDLE;
            sw_cnt_reg   <= 8'h00;
            swreq_reg    <= 1'b0;
        end
        else
        begin
            case (sw_state_reg)
                OCS_SW_IDLE:
                begin
                    if (hit_ctl && !sel_locked && ctl_new[OCS_POS_SWREQ])
                    begin
                        swreq_reg    <= 1'b1;
                        sw_cnt_reg   <= 8'(OCS_SWITCH_CYC);
                        sw_state_reg <= OCS_SW_WAIT;
                    end
                end
                OCS_SW_WAIT:
                begin
                    // the new source must settle before the mux flips
                    if (sw_cnt_reg <= 8'h01)
                        sw_state_reg <= OCS_SW_DONE;
                    sw_cnt_reg <= sw_cnt_reg - 8'h01;
                end
                OCS_SW_DONE:
                begin
                    swreq_reg    <= 1'b0;
                    sw_state_reg <= OCS_SW_IDLE;
                end
                default:
                    sw_state_reg <= OCS_SW_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock fail flag: hardware set wins over a software clear
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            fail_reg <= 1'b0;
        else if (osc_status.clock_failure)
            fail_reg <= 1'b1;
        else if (hit_ctl)
            fail_reg <= ctl_new[OCS_POS_FAIL];
    end

    // ------------------------------------------------------------
    // low power entry on wait
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            low_power_reg <= 1'b0;
        else if (wake_event)
            low_power_reg <= 1'b0;
        else if (wait_instr)
            low_power_reg <= 1'b1;
    end

    // ------------------------------------------------------------
    // status and read view
    // ------------------------------------------------------------
    logic srdy;
    logic sys_pll_locked;
    logic usb_pll_locked;

    assign srdy  = secondary_osc_enable_reg && osc_status.sec_osc_stable;
    assign sys_pll_locked = osc_status.sys_pll_lock || osc_status.sys_pll_timer_done;
    assign usb_pll_locked = osc_status.usb_pll_enabled &&
                   (osc_status.usb_pll_lock || osc_status.usb_pll_timer_done);

    always_comb
    begin
        ctl_word = 32'h00000000;
        ctl_word[OCS_POS_ODIV +: 3]   = odiv_reg;
        ctl_word[OCS_POS_FAST_RC_DIVIDER +: 3] = fast_rc_divider_reg;
        ctl_word[OCS_POS_SRDY]        = srdy;
        ctl_word[OCS_POS_PDRDY]       = !pd_busy_reg;
        ctl_word[OCS_POS_PERIPH_BUS_DIVIDER +: 2]  = periph_bus_divider_reg;
        ctl_word[OCS_POS_MULT +: 3]   = mult_reg;
        ctl_word[OCS_POS_CUR +: 3]    = cur_reg;
        ctl_word[OCS_POS_NEW +: 3]    = new_reg;
        ctl_word[OCS_POS_LOCK]        = lock_reg;
        ctl_word[OCS_POS_USB_PLL_LOCKED]       = usb_pll_locked;
        ctl_word[OCS_POS_SYS_PLL_LOCKED]       = sys_pll_locked;
        ctl_word[OCS_POS_SLEEP]       = sleep_reg;
        ctl_word[OCS_POS_FAIL]        = fail_reg;
        ctl_word[OCS_POS_UFRC]        = ufrc_reg;
        ctl_word[OCS_POS_SECONDARY_OSC_ENABLE]      = secondary_osc_enable_reg;
        ctl_word[OCS_POS_SWREQ]       = swreq_reg;
    end

    // read data is held in a flop so it stands through the data phase
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            hrdata <= 32'h00000000;
        else if (ap_valid && !hwrite)
        begin
            case ({haddr[15:4], 4'h0})
                OCS_OFF_CONTROL: hrdata <= ctl_word;
                OCS_OFF_TUNING:  hrdata <= tun_reg;
                OCS_OFF_REFCTRL: hrdata <= refctl_reg;
                OCS_OFF_REFTRIM: hrdata <= reftrim_reg;
                default:         hrdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock tree controls
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            clk_ctrl <= '0;
        else
        begin
            clk_ctrl.pll_out_div <= (odiv_reg == 3'h7) ? 9'h100 : 9'(9'h001 << odiv_reg);
            clk_ctrl.frc_div     <= (fast_rc_divider_reg == 3'h7) ? 9'h100 : 9'(9'h001 << fast_rc_divider_reg);
            clk_ctrl.pll_mult    <= (mult_reg == 3'h7) ? 5'h18 : 5'(5'h0F + mult_reg);
            clk_ctrl.pbus_div    <= 4'(4'h1 << periph_bus_divider_reg);
            clk_ctrl.source      <= cur_reg;
            clk_ctrl.frc_trim    <= tun_reg[5:0];
            clk_ctrl.sec_osc_en  <= secondary_osc_enable_reg;
            clk_ctrl.usb_frc_sel <= ufrc_reg;
            clk_ctrl.sleep_mode  <= low_power_reg && sleep_reg;
            clk_ctrl.idle_mode   <= low_power_reg && !sleep_reg;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/ocs_pkg.sv
package ocs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] OCS_OFF_CONTROL   = 16'hF000;
    localparam logic [15:0] OCS_OFF_TUNING    = 16'hF010;
    localparam logic [15:0] OCS_OFF_REFCTRL   = 16'hF020;
    localparam logic [15:0] OCS_OFF_REFTRIM   = 16'hF030;
    localparam logic [15:0] OCS_OFF_UNLOCK    = 16'hF040;
    localparam logic [1:0]  OCS_ALIAS_BASE    = 2'h0;
    localparam logic [1:0]  OCS_ALIAS_CLR     = 2'h1;
    localparam logic [1:0]  OCS_ALIAS_SET     = 2'h2;
    localparam logic [1:0]  OCS_ALIAS_INV     = 2'h3;

    // ------------------------------------------------------------
    // unlock sequence keys
    // ------------------------------------------------------------
    localparam logic [31:0] OCS_KEY_1         = 32'hAA996655;
    localparam logic [31:0] OCS_KEY_2         = 32'h556699AA;

    // ------------------------------------------------------------
    // control register field positions
    // ------------------------------------------------------------
    localparam int OCS_POS_ODIV    = 27;
    localparam int OCS_POS_FAST_RC_DIVIDER  = 24;
    localparam int OCS_POS_SRDY    = 22;
    localparam int OCS_POS_PDRDY   = 21;
    localparam int OCS_POS_PERIPH_BUS_DIVIDER   = 19;
    localparam int OCS_POS_MULT    = 16;
    localparam int OCS_POS_CUR     = 12;
    localparam int OCS_POS_NEW     = 8;
    localparam int OCS_POS_LOCK    = 7;
    localparam int OCS_POS_USB_PLL_LOCKED   = 6;
    localparam int OCS_POS_SYS_PLL_LOCKED   = 5;
    localparam int OCS_POS_SLEEP   = 4;
    localparam int OCS_POS_FAIL    = 3;
    localparam int OCS_POS_UFRC    = 2;
    localparam int OCS_POS_SECONDARY_OSC_ENABLE  = 1;
    localparam int OCS_POS_SWREQ   = 0;

    // writable bits of each register
    localparam logic [31:0] OCS_WMASK_CONTROL = 32'h397F0797;
    localparam logic [31:0] OCS_WMASK_TUNING  = 32'h0000003F;
    localparam logic [31:0] OCS_WMASK_REFCTRL = 32'h7FFFBA0F;
    localparam logic [31:0] OCS_WMASK_REFTRIM = 32'hFF800000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0]  OCS_RST_FAST_RC_DIVIDER    = 3'h1;
    localparam logic [1:0]  OCS_RST_PERIPH_BUS_DIVIDER     = 2'h3;
    localparam logic [2:0]  OCS_RST_ODIV      = 3'h0;
    localparam logic [2:0]  OCS_RST_MULT      = 3'h0;
    localparam logic [2:0]  OCS_RST_SRC       = 3'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int OCS_CLK_MHZ       = 250;
    localparam int OCS_SWITCH_NS     = 40;
    localparam int OCS_SWITCH_CYC    = (OCS_SWITCH_NS * OCS_CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // clock source encoding
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OCS_SRC_FRC      = 3'b000,
        OCS_SRC_FRC_PLL  = 3'b001,
        OCS_SRC_PRI      = 3'b010,
        OCS_SRC_PRI_PLL  = 3'b011,
        OCS_SRC_SEC      = 3'b100,
        OCS_SRC_LOW_POWER_RC_OSC     = 3'b101,
        OCS_SRC_FRC_D16  = 3'b110,
        OCS_SRC_FRC_DIV  = 3'b111
    } ocs_src_type;

    typedef enum logic [1:0]
    {
        OCS_SW_IDLE = 2'b00,
        OCS_SW_WAIT = 2'b01,
        OCS_SW_DONE = 2'b10
    } ocs_sw_state_type;

    // analog status from the oscillators and monitor
    typedef struct packed
    {
        logic sec_osc_stable;
        logic sys_pll_lock;
        logic sys_pll_timer_done;
        logic usb_pll_lock;
        logic usb_pll_timer_done;
        logic usb_pll_enabled;
        logic clock_failure;
    } ocs_status_type;

    // settings driven to the clock tree
    typedef struct packed
    {
        logic [8:0]  pll_out_div;
        logic [4:0]  pll_mult;
        logic [8:0]  frc_div;
        logic [3:0]  pbus_div;
        logic [2:0]  source;
        logic [5:0]  frc_trim;
        logic        sec_osc_en;
        logic        usb_frc_sel;
        logic        sleep_mode;
        logic        idle_mode;
    } ocs_ctrl_type;

endpackage

// ===== tb/ocs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ocs_chk
    import ocs_pkg::*;
(
    // clock and bus
    input wire logic                    ref_clk,
    input wire logic                    nrst,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic                    hready,
    input wire logic [31:0]             hrdata,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    // oscillator side
    input wire ocs_pkg::ocs_status_type osc_status,
    input wire ocs_pkg::ocs_ctrl_type   clk_ctrl
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic       acc;
    logic [1:0] up_reg;
    logic [1:0] rd_reg;
    assign acc = hsel & hready & htrans[1] & !hwrite;
    // tree outputs are only meaningful once the configuration word has landed
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            up_reg <= 2'h0;
            rd_reg <= 2'h0;
        end
        else
        begin
            up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
            rd_reg <= {acc && haddr[15:0] == 16'h0100, acc && haddr[15:0] == OCS_OFF_CONTROL};
        end
    end
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    odiv_code_a: assert property (up_reg == 2'h3 |-> $onehot(clk_ctrl.pll_out_div) && !clk_ctrl.pll_out_div[7])
        else $error("pll output divisor off its code table");
    frc_div_a: assert property (up_reg == 2'h3 |-> $onehot(clk_ctrl.frc_div) && !clk_ctrl.frc_div[7])
        else $error("fast rc divisor off its code table");
    pbus_div_a: assert property (up_reg == 2'h3 |-> $onehot(clk_ctrl.pbus_div))
        else $error("peripheral divisor not 1 2 4 8");
    mult_range_a: assert property (up_reg == 2'h3 |-> clk_ctrl.pll_mult inside {[15:21], 24})
        else $error("pll factor off its code table");
    mode_excl_a: assert property (!(clk_ctrl.sleep_mode && clk_ctrl.idle_mode))
        else $error("sleep and idle both on");
    sec_ready_a: assert property (rd_reg[0] && !$past(osc_status.sec_osc_stable) |-> !hrdata[22])
        else $error("secondary ready without stable oscillator");
    sys_lock_a: assert property (rd_reg[0] |-> hrdata[5] == $past(osc_status.sys_pll_lock | osc_status.sys_pll_timer_done))
        else $error("system pll lock bit wrong");
    usb_lock_a: assert property (rd_reg[0] |-> hrdata[6] == $past(osc_status.usb_pll_enabled
        & (osc_status.usb_pll_lock | osc_status.usb_pll_timer_done)))
        else $error("usb pll lock bit wrong");
    fail_flag_a: assert property (rd_reg[0] && $past(osc_status.clock_failure, 2) |-> hrdata[3])
        else $error("clock fail flag not set");
    unmapped_a: assert property (rd_reg[1] |-> hrdata == 32'h0) else $error("unmapped read not zero");
    cover property (rd_reg[0] && hrdata[3]);
    cover property (clk_ctrl.sleep_mode);
    cover property (rd_reg[1]);
endmodule
bind ocs_top ocs_chk ocs_chk_i (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .osc_status(osc_status), .clk_ctrl(clk_ctrl));
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import ocs_pkg::*;
    logic ref_clk, nrst, hsel, hwrite, hreadyout, hresp, wait_instr, wake_event, pbv;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans, smc;
    ocs_status_type osc_status;
    ocs_ctrl_type clk_ctrl;
    int n_errors, compares, cyc;
    ocs_top ocs_top_i (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .config_initial_source(3'h2), .switch_monitor_config(smc),
        .config_pll_out_div(3'h3), .config_pll_mult(3'h5), .config_pbus_div(2'h1),
        .config_pbus_div_valid(pbv), .osc_status(osc_status), .wait_instr(wait_instr),
        .wake_event(wake_event), .clk_ctrl(clk_ctrl));
    task automatic close_out();
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // called just after a rising edge; holds each phase until hready is seen high
    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic uwr(input logic [31:0] a, input logic [31:0] d);
        bus(OCS_OFF_UNLOCK, 1'b1, OCS_KEY_1);
        bus(OCS_OFF_UNLOCK, 1'b1, OCS_KEY_2);
        bus(a, 1'b1, d);
    endtask
    task automatic pulse(input logic s);
        if (s)
            wait_instr <= 1'b1;
        else
            wake_event <= 1'b1;
        @(posedge ref_clk);
        wait_instr <= 1'b0;
        wake_event <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            close_out();
        end
    end
    initial
    begin
        {nrst, hsel, hwrite, wait_instr, wake_event, htrans, smc, haddr, hwdata} = '0;
        osc_status = 7'h20;
        pbv = 1'b1;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("control", 32'h192D2220, q);
        chk("tree", {2'h0, 9'h8, 5'd20, 9'h2, 4'h2, 3'h2}, {2'h0, clk_ctrl[39:10]});
        bus(OCS_OFF_CONTROL + 32'h8, 1'b1, 32'h10);
        bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("locked write", 32'h192D2220, q);
        uwr(OCS_OFF_CONTROL + 32'h8, 32'h16);
        osc_status.sec_osc_stable <= 1'b1;
        pulse(1'b1);
        chk("sleep", 32'h1, {31'h0, clk_ctrl.sleep_mode});
        chk("sec enable", 32'h1, {31'h0, clk_ctrl.sec_osc_en});
        chk("usb frc", 32'h1, {31'h0, clk_ctrl.usb_frc_sel});
        pulse(1'b0);
        uwr(OCS_OFF_CONTROL + 32'h4, 32'h10);
        pulse(1'b1);
        chk("idle", 32'h1, {31'h0, clk_ctrl.idle_mode});
        uwr(OCS_OFF_CONTROL + 32'hC, 32'h601);
        for (int i = 0; i < 30 && (i == 0 || q[0] !== 1'b0); i++)
            bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("switched", 32'h00000192, {q[22], q[14:12], q[10:8], q[1:0]} & 32'h3FF);
        chk("switched hi", 32'h1, {31'h0, q[22]});
        chk("source", 32'h4, {29'h0, clk_ctrl.source});
        uwr(OCS_OFF_TUNING, 32'hFFFFFFE0);
        uwr(OCS_OFF_CONTROL + 32'h4, 32'h00180000);
        repeat (2) @(posedge ref_clk);
        chk("pbus", 32'h1, {28'h0, clk_ctrl.pbus_div});
        chk("trim", 32'h20, {26'h0, clk_ctrl.frc_trim});
        for (int c = 0; c < 8; c++)
        begin
            uwr(OCS_OFF_CONTROL + 32'h4, 32'h38000000);
            uwr(OCS_OFF_CONTROL + 32'h8, c << 27);
            repeat (2) @(posedge ref_clk);
            chk("odiv", (c == 7) ? 32'h100 : 32'h1 << c, {23'h0, clk_ctrl.pll_out_div});
        end
        osc_status.clock_failure <= 1'b1;
        repeat (2) @(posedge ref_clk);
        bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("fail", 32'h8, q & 32'h8);
        bus(32'h0100, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        smc <= 2'h2;
        uwr(OCS_OFF_CONTROL + 32'h8, 32'h80);
        uwr(OCS_OFF_CONTROL + 32'h4, 32'h38000000);
        bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("sel lock", 32'h7, {29'h0, q[29:27]});
        smc <= 2'h0;
        uwr(OCS_OFF_CONTROL + 32'h4, 32'h38000000);
        bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("no lock", 32'h0, {29'h0, q[29:27]});
        // second reset without a valid divider in the configuration word
        nrst <= 1'b0;
        pbv <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        bus(OCS_OFF_CONTROL, 1'b0, 32'h0);
        chk("reset again", 32'h193D2228, q);
        close_out();
    end
endmodule
`default_nettype wire
